// File: dbs_pkg.sv
// Package for the double-buffer display switch: register map, field layout,
// reset values, display timing counts, modes and carrier structs.
// Assumes a 10 MHz system clock and a 16-bit wide frame store word.
package dbs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the APB slave
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_CMD = 12'h004;
  localparam logic [11:0] OFF_STAT = 12'h008;
  localparam logic [11:0] OFF_BASE0 = 12'h00C;
  localparam logic [11:0] OFF_BASE1 = 12'h010;
  localparam logic [11:0] OFF_SWAPS = 12'h014;
  localparam logic [11:0] OFF_PAL = 12'h400;
  localparam logic [11:0] OFF_PAL_END = 12'h7FC;

  // Command register bit positions (write only, self clearing)
  localparam int CMD_DRAW_BIT = 0;
  localparam int CMD_DC_BIT = 1;

  // Status register bit positions
  localparam int STAT_DISP_SEL_BIT = 0;
  localparam int STAT_DC_BIT = 1;
  localparam int STAT_DRAW_LSB = 2;
  localparam int STAT_UNDER_BIT = 4;
  localparam int STAT_FIELD_BIT = 5;

  // Reset values
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [19:0] BASE0_RST = 20'h0_0000;
  localparam logic [19:0] BASE1_RST = 20'h1_0000;

  // Dot clock is the system clock divided by this figure
  localparam int DOT_DIV = 2;

  // Display timing in dots and lines
  localparam logic [9:0] H_ACT = 10'h140;
  localparam logic [9:0] H_SYNC_ON = 10'h150;
  localparam logic [9:0] H_SYNC_OFF = 10'h170;
  localparam logic [9:0] H_TOTAL = 10'h190;
  localparam logic [9:0] V_ACT = 10'h0F0;
  localparam logic [9:0] V_SYNC_ON = 10'h0F4;
  localparam logic [9:0] V_SYNC_OFF = 10'h0F7;
  localparam logic [9:0] V_TOTAL = 10'h106;

  ////////////////////////////////////////////////////////////////////////////
  // Modes and states
  typedef enum logic [1:0] {POL_AUTO_DISP, POL_AUTO_REND, POL_MANUAL} dbs_policy_e;
  typedef enum logic [1:0] {SCAN_NONINT, SCAN_INT, SCAN_INT_VIDEO} dbs_scan_e;
  typedef enum logic [1:0] {DRW_IDLE, DRW_WAIT, DRW_RUN, DRW_DONE} dbs_draw_e;

  // Control register layout, bit 5 down to bit 0
  typedef struct packed {
    logic en;
    logic bpp8;
    logic [1:0] scan;
    logic [1:0] policy;
  } dbs_ctrl_s;

  // Display pixel, 6 bits per colour
  typedef struct packed {
    logic [5:0] r;
    logic [5:0] g;
    logic [5:0] b;
  } dbs_rgb_s;

  // Widen a 5-6-5 word to the 18-bit display pixel
  function automatic dbs_rgb_s rgb565_to_18(input logic [15:0] w);
    dbs_rgb_s p;
    p.r = {w[15:11], w[15]};
    p.g = w[10:5];
    p.b = {w[4:0], w[4]};
    return p;
  endfunction

endpackage

// File: dbs_palette.sv
// Colour palette of 256 entries, 6 bits per colour component.
// One write port clocked on clk_sys and two combinational read ports.
`timescale 1ns/10ps
module dbs_palette (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [7:0] wr_idx,
  input wire dbs_pkg::dbs_rgb_s wr_data,
  input wire logic [7:0] pix_idx,
  output dbs_pkg::dbs_rgb_s pix_rgb,
  input wire logic [7:0] sw_idx,
  output dbs_pkg::dbs_rgb_s sw_rgb
);

  dbs_pkg::dbs_rgb_s table_mem [256];

  // Entry write from software
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      table_mem[wr_idx] <= wr_data;
    end
  end

  // Pixel lookup and software read back
  assign pix_rgb = table_mem[pix_idx];
  assign sw_rgb = table_mem[sw_idx];

endmodule // dbs_palette

// File: dbs_skid2.sv
// Two-entry buffer with valid and ready on both sides.
// Ready toward the filling side is a flip-flop; assumes one clock.
`timescale 1ns/10ps
module dbs_skid2 (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [15:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [15:0] out_data
);

  logic [15:0] slot [2];
  logic rd_ptr;
  logic wr_ptr;
  logic [1:0] count;
  logic push;
  logic pop;
  logic [1:0] next_count;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count != 2'h0);
  assign out_data = slot[rd_ptr];

  // Occupancy after this edge
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  // Pointers, count and registered ready
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count <= 2'h0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      in_ready <= 1'b1;
    end else begin
      count <= next_count;
      in_ready <= (next_count != 2'h2);
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
    end
  end

  // Storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      slot[wr_ptr] <= in_data;
    end
  end

endmodule // dbs_skid2

// File: dbs_display_switch.sv
// Double-buffer display switch: swap policy, scan timing, pixel fetch,
// palette translation and an APB register slave.
// Assumes the drawing engine and frame store sit on clk_sys.
//
// Contract
// (R1) Display-priority policy swaps at every boundary, aborting unfinished drawing.
// (R2) Rendering-priority policy swaps only at the first boundary after drawing ends.
// (R3) Software policy: software starts drawing, sets change request, swap at boundary.
// (R4) Non-interlaced scan: one field per frame, swaps on frame boundaries.
// (R5) Interlace: two fields; plain swaps per frame, sync-and-video per field.
// (R6) 8-bit pixels map through a 256-entry palette of 6-bit components.
// (R7) Pixels leave on an 18-bit output, 6 bits each of red, green, blue.
// (R8) Display logic runs at half the system clock rate.
// (R9) Pixels are fetched from the display buffer, paced by display timing.
// (R10) A swap exchanges display and drawing buffers in one step.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module dbs_display_switch (
  input wire logic clk_sys,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drawing engine
  input wire logic draw_busy,
  output logic draw_start,
  output logic draw_abort,
  output logic [19:0] draw_base,
  // Frame store read port
  output logic mem_req,
  output logic [19:0] mem_addr,
  input wire logic mem_rsp_valid,
  input wire logic [15:0] mem_rsp_data,
  output logic mem_rsp_ready,
  // Display output
  input wire logic dac_ready,
  output dbs_pkg::dbs_rgb_s rgb,
  output logic pix_en,
  output logic hsync_n,
  output logic vsync_n,
  output logic field
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  dbs_pkg::dbs_ctrl_s ctrl;
  logic [19:0] base0;
  logic [19:0] base1;
  logic [15:0] swap_count;
  logic disp_sel;
  logic dc_req;
  logic underrun;
  dbs_pkg::dbs_draw_e draw_state;
  logic dot_tick;
  logic [9:0] hcnt;
  logic [9:0] vcnt;
  logic line_end;
  logic field_end;
  logic boundary;
  logic swap;
  logic wr_acc;
  logic rd_setup;
  logic cmd_draw;
  logic cmd_dc;
  logic pal_hit;
  logic active;
  logic [19:0] fetch_ofs;
  logic fetch_busy;
  logic [19:0] fetch_end;
  logic buf_out_valid;
  logic buf_pop;
  logic [15:0] buf_data;
  logic half;
  logic pix_take;
  logic [7:0] pix_idx;
  dbs_pkg::dbs_rgb_s pal_pix;
  dbs_pkg::dbs_rgb_s pal_sw;
  logic [31:0] next_rdata;
  logic next_err;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign wr_acc = psel && penable && pwrite && pready;
  assign rd_setup = psel && !penable && !pwrite;
  assign cmd_draw = wr_acc && (paddr == dbs_pkg::OFF_CMD) && pwdata[dbs_pkg::CMD_DRAW_BIT];
  assign cmd_dc = wr_acc && (paddr == dbs_pkg::OFF_CMD) && pwdata[dbs_pkg::CMD_DC_BIT];
  assign pal_hit = (paddr >= dbs_pkg::OFF_PAL) && (paddr <= dbs_pkg::OFF_PAL_END)
                   && (paddr[1:0] == 2'h0);

  // Read mux and unmapped-address error
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (pal_hit) begin
      next_rdata = {14'h0000, pal_sw};
    end else begin
      unique case (paddr)
        dbs_pkg::OFF_CTRL: next_rdata = {26'h000_0000, ctrl};
        dbs_pkg::OFF_CMD: next_rdata = 32'h0000_0000;
        dbs_pkg::OFF_STAT: next_rdata = {26'h000_0000, field, underrun, draw_state,
                                         dc_req, disp_sel};
        dbs_pkg::OFF_BASE0: next_rdata = {12'h000, base0};
        dbs_pkg::OFF_BASE1: next_rdata = {12'h000, base1};
        dbs_pkg::OFF_SWAPS: next_rdata = {16'h0000, swap_count};
        default: next_err = 1'b1;
      endcase
    end
  end

  // Bus answer: zero wait, data captured in the setup cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        prdata <= rd_setup ? next_rdata : 32'h0000_0000;
        pslverr <= next_err;
      end
    end
  end

  // Writable configuration
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= dbs_pkg::CTRL_RST;
      base0 <= dbs_pkg::BASE0_RST;
      base1 <= dbs_pkg::BASE1_RST;
    end else if (wr_acc) begin
      unique case (paddr)
        dbs_pkg::OFF_CTRL: ctrl <= pwdata[5:0];
        dbs_pkg::OFF_BASE0: base0 <= pwdata[19:0];
        dbs_pkg::OFF_BASE1: base1 <= pwdata[19:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dot clock enable at half the system rate
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dot_tick <= 1'b0;
    end else begin
      dot_tick <= ~dot_tick; // R8
    end
  end

  assign line_end = dot_tick && (hcnt == dbs_pkg::H_TOTAL - 10'h001);
  assign field_end = line_end && (vcnt == dbs_pkg::V_TOTAL - 10'h001);
  assign active = (hcnt < dbs_pkg::H_ACT) && (vcnt < dbs_pkg::V_ACT);

  // Scan counters and field toggle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hcnt <= 10'h000;
      vcnt <= 10'h000;
      field <= 1'b0;
    end else if (dot_tick && ctrl.en) begin
      hcnt <= line_end ? 10'h000 : hcnt + 10'h001;
      if (line_end) begin
        vcnt <= field_end ? 10'h000 : vcnt + 10'h001;
      end
      if (field_end) begin
        field <= (ctrl.scan == dbs_pkg::SCAN_NONINT) ? 1'b0 : ~field; // R4 R5
      end
    end
  end

  // Sync pulses
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hsync_n <= 1'b1;
      vsync_n <= 1'b1;
    end else begin
      hsync_n <= !((hcnt >= dbs_pkg::H_SYNC_ON) && (hcnt < dbs_pkg::H_SYNC_OFF));
      vsync_n <= !((vcnt >= dbs_pkg::V_SYNC_ON) && (vcnt < dbs_pkg::V_SYNC_OFF));
    end
  end

  // Swap point: each field end, or only after the second field in plain interlace
  always_comb begin
    unique case (ctrl.scan)
      dbs_pkg::SCAN_NONINT: boundary = field_end; // R4
      dbs_pkg::SCAN_INT: boundary = field_end && field; // R5
      dbs_pkg::SCAN_INT_VIDEO: boundary = field_end; // R5
      default: boundary = field_end;
    endcase
    boundary = boundary && ctrl.en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Swap decision per policy
  always_comb begin
    unique case (ctrl.policy)
      dbs_pkg::POL_AUTO_DISP: swap = boundary; // R1
      dbs_pkg::POL_AUTO_REND: swap = boundary && (draw_state == dbs_pkg::DRW_DONE); // R2
      dbs_pkg::POL_MANUAL: swap = boundary && dc_req; // R3
      default: swap = 1'b0;
    endcase
  end

  // Buffer roles exchanged in one edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      disp_sel <= 1'b0;
      swap_count <= 16'h0000;
    end else if (swap) begin
      disp_sel <= ~disp_sel; // R10
      swap_count <= swap_count + 16'h0001;
    end
  end

  // Drawing target follows the buffer not on display
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      draw_base <= dbs_pkg::BASE1_RST;
    end else begin
      draw_base <= disp_sel ? base0 : base1; // R10
    end
  end

  // Change request: software set wins over the clear at a swap
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dc_req <= 1'b0;
    end else if (cmd_dc) begin
      dc_req <= 1'b1; // R3
    end else if (swap && ctrl.policy == dbs_pkg::POL_MANUAL) begin
      dc_req <= 1'b0; // R3
    end
  end

  // Drawing start and abort pulses
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      draw_start <= 1'b0;
      draw_abort <= 1'b0;
    end else begin
      draw_abort <= swap && (ctrl.policy == dbs_pkg::POL_AUTO_DISP)
                    && (draw_state != dbs_pkg::DRW_IDLE)
                    && (draw_state != dbs_pkg::DRW_DONE); // R1
      if (ctrl.policy == dbs_pkg::POL_MANUAL) begin
        draw_start <= cmd_draw; // R3
      end else begin
        draw_start <= swap || (ctrl.en && draw_state == dbs_pkg::DRW_IDLE && !draw_start);
      end
    end
  end

  // Drawing progress: started, seen busy, finished
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      draw_state <= dbs_pkg::DRW_IDLE;
    end else if (draw_abort) begin
      draw_state <= dbs_pkg::DRW_IDLE; // R1
    end else begin
      unique case (draw_state)
        dbs_pkg::DRW_IDLE: if (draw_start) draw_state <= dbs_pkg::DRW_WAIT;
        dbs_pkg::DRW_WAIT: if (draw_busy) draw_state <= dbs_pkg::DRW_RUN;
        dbs_pkg::DRW_RUN: if (!draw_busy) draw_state <= dbs_pkg::DRW_DONE; // R2
        dbs_pkg::DRW_DONE: if (draw_start) draw_state <= dbs_pkg::DRW_WAIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Words in one frame; 8-bit mode packs two pixels a word
  assign fetch_end = (20'(dbs_pkg::H_ACT) * 20'(dbs_pkg::V_ACT)) >> ctrl.bpp8;

  // Fetch from the display buffer, one request outstanding at a time
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mem_req <= 1'b0;
      mem_addr <= 20'h0_0000;
      fetch_ofs <= 20'h0_0000;
      fetch_busy <= 1'b0;
    end else begin
      mem_req <= 1'b0;
      if (mem_rsp_valid && mem_rsp_ready) begin
        fetch_busy <= 1'b0;
      end else if (!fetch_busy && mem_rsp_ready && ctrl.en && !field_end
                   && fetch_ofs < fetch_end) begin
        mem_req <= 1'b1;
        mem_addr <= (disp_sel ? base1 : base0) + fetch_ofs; // R9
        fetch_ofs <= fetch_ofs + 20'h0_0001;
        fetch_busy <= 1'b1;
      end
      if (field_end) begin
        fetch_ofs <= 20'h0_0000; // In-flight read still lands
      end
    end
  end

  dbs_skid2 u_buf (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(mem_rsp_valid),
    .in_ready(mem_rsp_ready),
    .in_data(mem_rsp_data),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_data)
  );

  // Pixel drain paced by the dot tick and the DAC
  assign pix_take = dot_tick && active && ctrl.en && dac_ready; // R9
  assign buf_pop = pix_take && buf_out_valid && (!ctrl.bpp8 || half);
  assign pix_idx = half ? buf_data[15:8] : buf_data[7:0];

  dbs_palette u_pal (
    .clk_sys(clk_sys),
    .wr_en(wr_acc && pal_hit),
    .wr_idx(paddr[9:2]),
    .wr_data(pwdata[17:0]),
    .pix_idx(pix_idx),
    .pix_rgb(pal_pix),
    .sw_idx(paddr[9:2]),
    .sw_rgb(pal_sw)
  );

  // Byte half within the word in 8-bit mode
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      half <= 1'b0;
    end else if (field_end || !ctrl.bpp8) begin
      half <= 1'b0;
    end else if (pix_take && buf_out_valid) begin
      half <= ~half;
    end
  end

  // Output pixel register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rgb <= 18'h0_0000;
      pix_en <= 1'b0;
    end else if (dot_tick) begin
      pix_en <= active && ctrl.en;
      if (!(active && ctrl.en)) begin
        rgb <= 18'h0_0000;
      end else if (pix_take && buf_out_valid) begin
        rgb <= ctrl.bpp8 ? pal_pix : dbs_pkg::rgb565_to_18(buf_data); // R6 R7
      end
    end
  end

  // Sticky underrun, write one to clear; a new event wins
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      underrun <= 1'b0;
    end else if (pix_take && !buf_out_valid) begin
      underrun <= 1'b1;
    end else if (wr_acc && paddr == dbs_pkg::OFF_STAT && pwdata[dbs_pkg::STAT_UNDER_BIT]) begin
      underrun <= 1'b0;
    end
  end

endmodule // dbs_display_switch

// File: dbs_display_switch_chk.sv
// Port checker for the double-buffer display switch.
// Assumes one clk_sys domain and software that leaves the bases alone.
`timescale 1ns/10ps
module dbs_display_switch_chk (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic draw_abort,
  input wire logic [19:0] draw_base,
  input wire logic mem_req,
  input wire logic [19:0] mem_addr,
  input wire logic mem_rsp_valid,
  input wire logic mem_rsp_ready,
  input wire dbs_pkg::dbs_rgb_s rgb,
  input wire logic hsync_n,
  input wire logic vsync_n
);
  localparam logic [7:0] HS_W = 8'((dbs_pkg::H_SYNC_OFF - dbs_pkg::H_SYNC_ON) * dbs_pkg::DOT_DIV);
  localparam logic [11:0] VS_W = 12'((dbs_pkg::V_SYNC_OFF - dbs_pkg::V_SYNC_ON)
    * dbs_pkg::H_TOTAL * dbs_pkg::DOT_DIV);
  logic [1:0] pol;
  logic pend;
  logic [7:0] hcnt;
  logic [11:0] vlen;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  //////////////////////////////////////////////////////////////////////////////
  // Policy as last written by software
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) pol <= 2'h0;
    else if (psel && penable && pwrite && paddr == dbs_pkg::OFF_CTRL) pol <= pwdata[1:0];
  end
  // Read outstanding toward the frame store
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) pend <= 1'b0;
    else if (mem_req) pend <= 1'b1;
    else if (mem_rsp_valid && mem_rsp_ready) pend <= 1'b0;
  end
  // Length of the line sync pulse so far
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) hcnt <= 8'h0;
    else if (!hsync_n) hcnt <= hcnt + 8'h1;
    else hcnt <= 8'h0;
  end
  // Length of the frame sync pulse so far
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) vlen <= 12'h0;
    else if (!vsync_n) vlen <= vlen + 12'h1;
    else vlen <= 12'h0;
  end
  //////////////////////////////////////////////////////////////////////////////
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  property p_unmapped;
    psel && penable && paddr > dbs_pkg::OFF_SWAPS && paddr < dbs_pkg::OFF_PAL
      |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole not refused");
  property p_req_pulse; mem_req |=> !mem_req; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request too long");
  property p_one_out; mem_req |-> !pend; endproperty
  a_one_out: assert property (p_one_out) else $error("second read outstanding");
  property p_addr_hold; !mem_req |-> $stable(mem_addr); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  property p_dot_rate; $changed(rgb) |=> $stable(rgb); endproperty
  a_dot_rate: assert property (p_dot_rate) else $error("pixel faster than dot");
  property p_abort; draw_abort |-> pol == dbs_pkg::POL_AUTO_DISP ##1 !draw_abort; endproperty
  a_abort: assert property (p_abort) else $error("abort out of policy");
  property p_hsync; $rose(hsync_n) |-> hcnt == HS_W; endproperty
  a_hsync: assert property (p_hsync) else $error("sync width wrong");
  property p_vsync; $rose(vsync_n) |-> vlen == VS_W; endproperty
  a_vsync: assert property (p_vsync) else $error("frame sync width wrong");
  property p_base;
    draw_base == dbs_pkg::BASE0_RST || draw_base == dbs_pkg::BASE1_RST;
  endproperty
  a_base: assert property (p_base) else $error("drawing base not a buffer");
endmodule // dbs_display_switch_chk

bind dbs_display_switch dbs_display_switch_chk u_chk (.clk_sys, .arst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .draw_abort, .draw_base, .mem_req,
  .mem_addr, .mem_rsp_valid, .mem_rsp_ready, .rgb, .hsync_n, .vsync_n);

// File: dbs_far_side.sv
// Far-side model: frame store read port and the DAC taking pixels.
// Assumes one outstanding read; the bench sets fill data and slow mode.
`timescale 1ns/10ps
module dbs_far_side (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic slow,
  input wire logic [15:0] fill,
  input wire logic mem_req,
  input wire logic mem_rsp_ready,
  output logic mem_rsp_valid,
  output logic [15:0] mem_rsp_data,
  output logic dac_ready
);
  logic [2:0] wait_cnt;
  logic [1:0] tick;
  // Answer after one or seven cycles, held until taken
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wait_cnt <= 3'h0;
      mem_rsp_valid <= 1'b0;
      mem_rsp_data <= 16'h0;
    end else if (mem_req) begin
      wait_cnt <= slow ? 3'h7 : 3'h1;
    end else if (wait_cnt == 3'h1) begin
      wait_cnt <= 3'h0;
      mem_rsp_valid <= 1'b1;
      mem_rsp_data <= fill;
    end else if (wait_cnt != 3'h0) begin
      wait_cnt <= wait_cnt - 3'h1;
    end else if (mem_rsp_valid && mem_rsp_ready) begin
      mem_rsp_valid <= 1'b0;
      mem_rsp_data <= ~fill; // Junk once released
    end
  end
  // Slow DAC takes one pixel in four cycles
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) tick <= 2'h0;
    else tick <= tick + 2'h1;
  end
  assign dac_ready = !slow || tick == 2'h3;
endmodule // dbs_far_side

// File: dbs_display_switch_test.sv
// Bench for the double-buffer display switch: registers, swap policies,
// scan modes and palette output. Assumes the far-side model and checker.
`timescale 1ns/10ps
module dbs_display_switch_test;
  localparam int FRAME = int'(dbs_pkg::H_TOTAL) * int'(dbs_pkg::V_TOTAL) * dbs_pkg::DOT_DIV;
  logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, e, f0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic draw_busy, draw_start, draw_abort, draw_fin, mem_req, mem_rsp_valid, mem_rsp_ready;
  logic [19:0] draw_base, mem_addr;
  logic [15:0] mem_rsp_data, fill;
  logic dac_ready, pix_en, hsync_n, vsync_n, field, slow;
  dbs_pkg::dbs_rgb_s rgb;
  int bad_count, checks, abort_cnt, n0;

  dbs_display_switch dut (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .draw_busy, .draw_start, .draw_abort, .draw_base, .mem_req,
    .mem_addr, .mem_rsp_valid, .mem_rsp_data, .mem_rsp_ready, .dac_ready, .rgb, .pix_en,
    .hsync_n, .vsync_n, .field);
  dbs_far_side far (.clk_sys, .arst_n, .slow, .fill, .mem_req, .mem_rsp_ready,
    .mem_rsp_valid, .mem_rsp_data, .dac_ready);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Drawing engine: busy from start until finished or aborted
  always @(posedge clk_sys) begin
    if (draw_start) draw_busy <= 1'b1;
    else if (draw_fin || draw_abort) draw_busy <= 1'b0;
    if (draw_abort) abort_cnt <= abort_cnt + 1;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer, read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, q, exp);
  endtask
  task automatic fin;
    draw_fin <= 1'b1;
    @(posedge clk_sys);
    draw_fin <= 1'b0;
  endtask
  // Wait for the next line's pixels to flow
  task automatic line_start;
    for (n0 = 0; n0 < 2000 && pix_en === 1'b1; n0++) @(posedge clk_sys);
    for (n0 = 0; n0 < FRAME && pix_en !== 1'b1; n0++) @(posedge clk_sys);
    repeat (40) @(posedge clk_sys);
  endtask
  task automatic summarize;
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Reset values, refused hole, palette width, entry for the fill pixel
  task automatic t_regs;
    rd(dbs_pkg::OFF_CTRL, 32'(dbs_pkg::CTRL_RST), "ctrl");
    rd(dbs_pkg::OFF_BASE1, 32'(dbs_pkg::BASE1_RST), "base1");
    rd(dbs_pkg::OFF_STAT, 32'h0, "stat");
    rd(12'h018, 32'h0, "hole");
    chk("slverr", 32'(e), 32'h1);
    apb(1'b1, 12'h7fc, 32'hffff_ffff);
    rd(12'h7fc, 32'h0003_ffff, "pal255");
    apb(1'b1, 12'h568, 32'h0002_b5c3);
  endtask
  // Rendering priority: no swap while busy, swap once drawing ends
  task automatic t_rend;
    apb(1'b1, dbs_pkg::OFF_CTRL, 32'h31);
    repeat (FRAME * 3 / 2) @(posedge clk_sys);
    rd(dbs_pkg::OFF_SWAPS, 32'h0, "swaps held");
    chk("base", 32'(draw_base), 32'(dbs_pkg::BASE1_RST));
    line_start;
    chk("rgb", 32'(rgb), 32'h0002_b5c3);
    fin;
    repeat (FRAME) @(posedge clk_sys);
    rd(dbs_pkg::OFF_SWAPS, 32'h1, "swaps");
    chk("field", 32'(field), 32'h0);
    chk("base", 32'(draw_base), 32'(dbs_pkg::BASE0_RST));
  endtask
  // Display priority, field swaps, 16-bit pixels, slow far side: swap aborts drawing
  task automatic t_disp;
    n0 = abort_cnt;
    slow <= 1'b1;
    apb(1'b1, dbs_pkg::OFF_CTRL, 32'h28);
    repeat (FRAME) @(posedge clk_sys);
    slow <= 1'b0;
    rd(dbs_pkg::OFF_SWAPS, 32'h2, "swaps");
    chk("aborts", 32'(abort_cnt - n0), 32'h1);
    line_start;
    chk("rgb 16", 32'(rgb), 32'h0001_64b5);
  endtask
  // Software policy, plain interlace: start, change request, swap per frame
  task automatic t_man;
    apb(1'b1, dbs_pkg::OFF_CTRL, 32'h36);
    fin;
    apb(1'b1, dbs_pkg::OFF_CMD, 32'h1);
    repeat (20) @(posedge clk_sys);
    chk("busy", 32'(draw_busy), 32'h1);
    fin;
    apb(1'b1, dbs_pkg::OFF_CMD, 32'h2);
    apb(1'b0, dbs_pkg::OFF_STAT, 32'h0);
    chk("dc set", q & 32'h3, 32'h2);
    chk("drawn", q & 32'hc, 32'hc);
    f0 = field;
    repeat (FRAME) @(posedge clk_sys);
    rd(dbs_pkg::OFF_SWAPS, 32'h3, "swaps");
    apb(1'b0, dbs_pkg::OFF_STAT, 32'h0);
    chk("dc clear", q & 32'h3, 32'h1);
    chk("drawn", q & 32'hc, 32'hc);
    chk("field", 32'(field), 32'(!f0));
    apb(1'b1, dbs_pkg::OFF_CMD, 32'h2);
    repeat (FRAME) @(posedge clk_sys);
    rd(dbs_pkg::OFF_SWAPS, 32'h3, "swaps per frame");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, draw_busy, draw_fin, slow, arst_n} = 7'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    fill = 16'h5a5a;
    {abort_cnt, bad_count, checks} = '0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_regs;
    t_rend;
    t_disp;
    t_man;
    summarize;
  end
  // Watchdog well past the five and a half frames the run needs
  initial begin
    repeat (7 * FRAME) @(posedge clk_sys);
    bad_count++;
    summarize;
  end
endmodule // dbs_display_switch_test
